/* ssi_decoder_defs.vh */
// constants shared by the serial absolute encoder decoder files
`ifndef SSI_DECODER_DEFS_VH
`define SSI_DECODER_DEFS_VH

`define CLK_PERIOD_NS 10

// register byte offsets
`define OFS_CTRL 8'h00
`define OFS_WIDTH 8'h04
`define OFS_LEAD_MASK 8'h08
`define OFS_TRAIL_MASK 8'h0c
`define OFS_STATUS 8'h10
`define OFS_POSITION 8'h14
`define OFS_RAW_ST 8'h18
`define OFS_RAW_MT 8'h1c

// control register bits
`define CTRL_START 0
`define CTRL_MOTOR 1
`define CTRL_CONT 2

// width register fields
`define WIDTH_ST_LSB 0
`define WIDTH_MT_LSB 8
`define WIDTH_FLD_W 6
`define WIDTH_MAX 6'h20
`define ST_BITS_RST 6'h0d
`define MT_BITS_RST 6'h0d

// extra-bit mask register: entry i in bits [2i+1:2i], entry 0 sent first; count in [19:16]
`define MASK_CNT_LSB 16
`define MASK_CNT_W 4
`define MASK_RST 20'h00000
`define MASK_MAX_BITS 4'h8
`define ENT_DONT_CARE 2'h0
`define ENT_FAIL_HIGH 2'h1
`define ENT_FAIL_LOW 2'h2

// status register bits
`define STAT_BUSY 0
`define STAT_FAULT_A 1
`define STAT_FAULT_B 2
`define STAT_NEW_POS 3

// link timing
`define SSI_CLK_HALF_NS 500
`define SSI_CLK_HALF_CYC ((`SSI_CLK_HALF_NS) / (`CLK_PERIOD_NS))
`define SSI_MONO_NS 20000
`define SSI_MONO_CYC (((`SSI_MONO_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))

// internal position word
`define ANGLE_BITS 16
`define REV_BITS 16

`endif

/* extra_bit_checker.v */
// checks one group of up to eight extra bits against its polarity mask
`timescale 1ns/10ps
`default_nettype none
`include "ssi_decoder_defs.vh"

module extra_bit_checker (
  input wire [7:0] bits,
  input wire [3:0] count,
  input wire [15:0] mask,
  output reg fault
);
  integer i;
  reg [3:0] pos;
  reg b;
  reg [1:0] ent;

  always @*
  begin
    fault = 1'b0;
    pos = 4'h0;
    b = 1'b0;
    ent = `ENT_DONT_CARE;
    // bits are right aligned, the last one received sits at bit 0
    for (i = 0; i < 8; i = i + 1)
    begin
      if (i < count)
      begin
        pos = count - 4'h1 - i[3:0];
        b = bits[pos[2:0]];
        ent = mask[2*i +: 2];
        if (ent == `ENT_FAIL_HIGH && b)
          fault = 1'b1;
        if (ent == `ENT_FAIL_LOW && !b)
          fault = 1'b1;
        // don't-care entries never contribute
      end
    end
  end
endmodule // extra_bit_checker

`default_nettype wire

/* position_mapper.v */
// maps raw singleturn and multiturn fields onto the 32-bit position word
`timescale 1ns/10ps
`default_nettype none
`include "ssi_decoder_defs.vh"

module position_mapper (
  input wire [31:0] st_raw,
  input wire [5:0] st_bits,
  input wire [31:0] mt_raw,
  input wire [5:0] mt_bits,
  input wire motor_mode,
  input wire [15:0] prev_rev,
  output reg [31:0] position
);
  reg [15:0] angle;
  reg [15:0] rev;
  reg [15:0] mt_mask;
  reg [15:0] delta;
  reg [31:0] scaled;

  always @*
  begin
    scaled = 32'h00000000;
    mt_mask = 16'h0000;
    delta = 16'h0000;
    if (!motor_mode || st_bits == 6'h00)
      scaled = st_raw;
    else if (st_bits <= 6'h10)
      scaled = st_raw << (6'h10 - st_bits);
    else
      scaled = st_raw >> (st_bits - 6'h10);
    angle = scaled[15:0];
    if (mt_bits == 6'h00)
      rev = prev_rev;
    else if (mt_bits >= 6'h10)
      rev = mt_raw[15:0];
    else
    begin
      // follow wraps of the short counter; a jump of half its range or more counts as backward
      mt_mask = (16'h0001 << mt_bits[3:0]) - 16'h0001;
      delta = (mt_raw[15:0] - prev_rev) & mt_mask;
      if (delta > (mt_mask >> 1))
        rev = prev_rev + delta - mt_mask - 16'h0001;
      else
        rev = prev_rev + delta;
    end
    position = {rev, angle};
  end
endmodule // position_mapper

`default_nettype wire

/* ssi_position_decoder.v */
// serial absolute encoder reader with field splitting, extra-bit checks and APB registers
`timescale 1ns/10ps
`default_nettype none
`include "ssi_decoder_defs.vh"

module ssi_position_decoder #(
  parameter CLK_HALF = `SSI_CLK_HALF_CYC,
  parameter MONO_CYC = `SSI_MONO_CYC
) (
  input wire clk,
  input wire rst_b,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  output reg ssi_clk,
  input wire ssi_data,
  input wire reported_valid,
  input wire [5:0] reported_st_bits,
  input wire [5:0] reported_mt_bits,
  output reg [31:0] position,
  output reg position_strobe,
  output wire extra_bit_fault_a,
  output wire extra_bit_fault_b
);
  localparam [4:0] S_IDLE = 5'b00001;
  localparam [4:0] S_LOW = 5'b00010;
  localparam [4:0] S_HIGH = 5'b00100;
  localparam [4:0] S_DONE = 5'b01000;
  localparam [4:0] S_MONO = 5'b10000;
  localparam [15:0] HALF_LAST = CLK_HALF[15:0] - 16'h0001;
  localparam [15:0] MONO_LAST = MONO_CYC[15:0] - 16'h0001;

  function [5:0] clamp_width;
    input [5:0] w;
    begin
      clamp_width = (w > `WIDTH_MAX) ? `WIDTH_MAX : w;
    end
  endfunction

  function [3:0] clamp_count;
    input [3:0] c;
    begin
      clamp_count = (c > `MASK_MAX_BITS) ? `MASK_MAX_BITS : c;
    end
  endfunction

  // field of up to 32 bits taken from the frame at a given offset from its last bit
  function [31:0] frame_field;
    input [79:0] frame;
    input [6:0] shift;
    input [5:0] width;
    reg [79:0] tmp;
    reg [79:0] msk;
    begin
      tmp = frame >> shift;
      msk = ({80{1'b0}} | {{48{1'b0}}, 32'hffffffff}) >> (6'h20 - width);
      if (width == 6'h00)
        msk = {80{1'b0}};
      tmp = tmp & msk;
      frame_field = tmp[31:0];
    end
  endfunction

  reg [4:0] state_reg, state_next;
  reg [2:0] ctrl_reg;
  reg [5:0] st_cfg_reg, mt_cfg_reg;
  reg [19:0] lead_mask_reg, trail_mask_reg;
  reg fault_a_reg, fault_b_reg, new_pos_reg;
  reg start_req_reg;
  reg [15:0] prev_rev_reg;
  reg [31:0] raw_st_reg, raw_mt_reg;
  reg sync1_reg, sync2_reg, sync3_reg, data_filt_reg;
  reg [15:0] tick_reg;
  reg [6:0] bit_cnt_reg;
  reg [79:0] shift_reg;
  reg [5:0] w_st_reg, w_mt_reg;
  reg [3:0] w_lead_reg, w_trail_reg;
  reg [15:0] m_lead_reg, m_trail_reg;
  reg motor_reg;

  wire setup_ph = psel & ~penable;
  wire wr_acc = psel & penable & pwrite;
  wire [5:0] eff_st = reported_valid ? clamp_width(reported_st_bits) : st_cfg_reg;
  wire [5:0] eff_mt = reported_valid ? clamp_width(reported_mt_bits) : mt_cfg_reg;
  wire [3:0] eff_lead = clamp_count(lead_mask_reg[`MASK_CNT_LSB +: `MASK_CNT_W]);
  wire [3:0] eff_trail = clamp_count(trail_mask_reg[`MASK_CNT_LSB +: `MASK_CNT_W]);
  wire [6:0] frame_bits = {3'h0, eff_lead} + {1'b0, eff_mt} + {1'b0, eff_st}
    + {3'h0, eff_trail};
  wire [6:0] sh_st = {3'h0, w_trail_reg};
  wire [6:0] sh_mt = sh_st + {1'b0, w_st_reg};
  wire [6:0] sh_lead = sh_mt + {1'b0, w_mt_reg};
  wire [31:0] st_field = frame_field(shift_reg, sh_st, w_st_reg);
  wire [31:0] mt_field = frame_field(shift_reg, sh_mt, w_mt_reg);
  wire [31:0] lead_word = frame_field(shift_reg, sh_lead, {2'h0, w_lead_reg});
  wire [31:0] trail_word = frame_field(shift_reg, 7'h00, {2'h0, w_trail_reg});
  wire lead_fault, trail_fault;
  wire [31:0] mapped;
  wire done = state_reg[3];
  wire frame_bad = lead_fault | trail_fault;
  wire clr_wr = wr_acc && paddr == `OFS_STATUS;
  wire start_now = start_req_reg | ctrl_reg[`CTRL_CONT];

  extra_bit_checker u_lead_chk (
    .bits(lead_word[7:0]),
    .count(w_lead_reg),
    .mask(m_lead_reg),
    .fault(lead_fault)
  );

  extra_bit_checker u_trail_chk (
    .bits(trail_word[7:0]),
    .count(w_trail_reg),
    .mask(m_trail_reg),
    .fault(trail_fault)
  );

  position_mapper u_map (
    .st_raw(st_field),
    .st_bits(w_st_reg),
    .mt_raw(mt_field),
    .mt_bits(w_mt_reg),
    .motor_mode(motor_reg),
    .prev_rev(prev_rev_reg),
    .position(mapped)
  );

  assign pready = 1'b1;
  assign pslverr = psel & penable & (paddr[1:0] != 2'h0 || paddr > `OFS_RAW_MT);
  assign extra_bit_fault_a = fault_a_reg;
  assign extra_bit_fault_b = fault_b_reg;

  // data input is asynchronous to clk; filtered copy follows once stages 2 and 3 agree
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
      sync3_reg <= 1'b1;
      data_filt_reg <= 1'b1;
    end
    else
    begin
      sync1_reg <= ssi_data;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      if (sync2_reg == sync3_reg)
        data_filt_reg <= sync3_reg;
    end
  end

  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE:
        if (start_now && frame_bits != 7'h00)
          state_next = S_LOW;
      S_LOW:
        if (tick_reg == HALF_LAST)
          state_next = S_HIGH;
      S_HIGH:
        if (tick_reg == HALF_LAST)
          state_next = (bit_cnt_reg == 7'h01) ? S_DONE : S_LOW;
      S_DONE:
        state_next = S_MONO;
      S_MONO:
        if (tick_reg == MONO_LAST)
          state_next = S_IDLE;
      default:
        state_next = S_IDLE;
    endcase
  end

  // link side: clock idles high, encoder shifts after each rising edge and the
  // bit is taken at the end of the high half so the synchroniser delay is covered
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      state_reg <= S_IDLE;
      ssi_clk <= 1'b1;
      tick_reg <= 16'h0000;
      bit_cnt_reg <= 7'h00;
      shift_reg <= {80{1'b0}};
      w_st_reg <= `ST_BITS_RST;
      w_mt_reg <= `MT_BITS_RST;
      w_lead_reg <= 4'h0;
      w_trail_reg <= 4'h0;
      m_lead_reg <= 16'h0000;
      m_trail_reg <= 16'h0000;
      motor_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      tick_reg <= (state_next != state_reg) ? 16'h0000 : tick_reg + 16'h0001;
      ssi_clk <= ~state_next[1];
      if (state_reg[0] && state_next[1])
      begin
        // settings frozen for the whole frame
        w_st_reg <= eff_st;
        w_mt_reg <= eff_mt;
        w_lead_reg <= eff_lead;
        w_trail_reg <= eff_trail;
        m_lead_reg <= lead_mask_reg[15:0];
        m_trail_reg <= trail_mask_reg[15:0];
        motor_reg <= ctrl_reg[`CTRL_MOTOR];
        bit_cnt_reg <= frame_bits;
        shift_reg <= {80{1'b0}};
      end
      else if (state_reg[2] && tick_reg == HALF_LAST)
      begin
        shift_reg <= {shift_reg[78:0], data_filt_reg};
        bit_cnt_reg <= bit_cnt_reg - 7'h01;
      end
    end
  end

  // results of a finished frame
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      position <= 32'h00000000;
      position_strobe <= 1'b0;
      prev_rev_reg <= 16'h0000;
      raw_st_reg <= 32'h00000000;
      raw_mt_reg <= 32'h00000000;
      fault_a_reg <= 1'b0;
      fault_b_reg <= 1'b0;
      new_pos_reg <= 1'b0;
    end
    else
    begin
      position_strobe <= done & ~frame_bad;
      if (done && !frame_bad)
      begin
        position <= mapped;
        prev_rev_reg <= mapped[31:16];
        raw_st_reg <= st_field;
        raw_mt_reg <= mt_field;
      end
      // a fault arriving with a clear still sets the flag
      fault_a_reg <= (done & lead_fault)
        | (fault_a_reg & ~(clr_wr & pwdata[`STAT_FAULT_A]));
      fault_b_reg <= (done & trail_fault)
        | (fault_b_reg & ~(clr_wr & pwdata[`STAT_FAULT_B]));
      new_pos_reg <= (done & ~frame_bad)
        | (new_pos_reg & ~(clr_wr & pwdata[`STAT_NEW_POS]));
    end
  end

  // configuration registers
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      ctrl_reg <= 3'h0;
      start_req_reg <= 1'b0;
      st_cfg_reg <= `ST_BITS_RST;
      mt_cfg_reg <= `MT_BITS_RST;
      lead_mask_reg <= `MASK_RST;
      trail_mask_reg <= `MASK_RST;
    end
    else
    begin
      if (state_reg[0] && start_now)
        start_req_reg <= 1'b0;
      if (wr_acc)
      begin
        case (paddr)
          `OFS_CTRL:
          begin
            ctrl_reg <= {pwdata[`CTRL_CONT], pwdata[`CTRL_MOTOR], 1'b0};
            if (pwdata[`CTRL_START])
              start_req_reg <= 1'b1;
          end
          `OFS_WIDTH:
          begin
            st_cfg_reg <= clamp_width(pwdata[`WIDTH_ST_LSB +: `WIDTH_FLD_W]);
            mt_cfg_reg <= clamp_width(pwdata[`WIDTH_MT_LSB +: `WIDTH_FLD_W]);
          end
          `OFS_LEAD_MASK:
            lead_mask_reg <= pwdata[19:0];
          `OFS_TRAIL_MASK:
            trail_mask_reg <= pwdata[19:0];
          default:
            ctrl_reg <= ctrl_reg;
        endcase
      end
    end
  end

  // read data is captured in the setup phase and presented in the access phase
  always @(posedge clk)
  begin
    if (!rst_b)
      prdata <= 32'h00000000;
    else if (setup_ph && !pwrite)
    begin
      case (paddr)
        `OFS_CTRL:
          prdata <= {29'h0, ctrl_reg[2:1], start_req_reg};
        `OFS_WIDTH:
          prdata <= {18'h0, eff_mt, 2'h0, eff_st};
        `OFS_LEAD_MASK:
          prdata <= {12'h0, lead_mask_reg};
        `OFS_TRAIL_MASK:
          prdata <= {12'h0, trail_mask_reg};
        `OFS_STATUS:
          prdata <= {28'h0, new_pos_reg, fault_b_reg, fault_a_reg, ~state_reg[0]};
        `OFS_POSITION:
          prdata <= position;
        `OFS_RAW_ST:
          prdata <= raw_st_reg;
        `OFS_RAW_MT:
          prdata <= raw_mt_reg;
        default:
          prdata <= 32'h00000000;
      endcase
    end
  end
endmodule // ssi_position_decoder

`default_nettype wire

/* ssi_decoder_asserts.sv */
// concurrent checks on the serial position decoder ports
`timescale 1ns/10ps
`default_nettype none
module ssi_decoder_asserts #(
  parameter CLK_HALF = 8,
  parameter MONO_CYC = 20
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic ssi_clk,
  input wire logic [31:0] position,
  input wire logic position_strobe,
  input wire logic extra_bit_fault_a,
  input wire logic extra_bit_fault_b
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic [15:0] lo_cnt;
  logic [15:0] hi_cnt;
  // high count saturates so a long idle still meets the pause check
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      lo_cnt <= 16'h0000;
      hi_cnt <= 16'hffff;
    end
    else
    begin
      lo_cnt <= ssi_clk ? 16'h0000 : lo_cnt + 16'h0001;
      hi_cnt <= !ssi_clk ? 16'h0000 : (&hi_cnt ? hi_cnt : hi_cnt + 16'h0001);
    end
  end
  property p_ready; pready; endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  property p_slverr; pslverr == (psel && penable && (paddr[1:0] != 2'h0 || paddr > 8'h1c));
  endproperty
  a_slverr: assert property (p_slverr) else $error("pslverr wrong");
  property p_pulse; position_strobe |=> !position_strobe; endproperty
  a_pulse: assert property (p_pulse) else $error("strobe too long");
  property p_hold; !position_strobe |-> $stable(position); endproperty
  a_hold: assert property (p_hold) else $error("position moved without strobe");
  property p_fa; $fell(extra_bit_fault_a)
    |-> $past(psel && penable && pwrite && paddr == 8'h10 && pwdata[1]);
  endproperty
  a_fa: assert property (p_fa) else $error("fault a dropped alone");
  property p_fb; $fell(extra_bit_fault_b)
    |-> $past(psel && penable && pwrite && paddr == 8'h10 && pwdata[2]);
  endproperty
  a_fb: assert property (p_fb) else $error("fault b dropped alone");
  property p_low; $rose(ssi_clk) |-> lo_cnt == CLK_HALF; endproperty
  a_low: assert property (p_low) else $error("low half length");
  property p_high; $fell(ssi_clk) |-> hi_cnt == CLK_HALF || hi_cnt >= MONO_CYC; endproperty
  a_high: assert property (p_high) else $error("high half or pause length");
  property p_nofault; position_strobe |-> !$rose(extra_bit_fault_a) && !$rose(extra_bit_fault_b);
  endproperty
  a_nofault: assert property (p_nofault) else $error("strobe on faulty frame");
  c_strobe: cover property (position_strobe);
  c_fault: cover property ($rose(extra_bit_fault_b));
  c_err: cover property (pslverr);
endmodule // ssi_decoder_asserts
`default_nettype wire

/* ssi_encoder_model.sv */
// behavioural serial absolute encoder driving one frame per clock burst
`timescale 1ns/10ps
`default_nettype none
module ssi_encoder_model (
  input wire logic rst_b,
  input wire logic ssi_clk,
  input wire logic [79:0] frame,
  input wire logic [6:0] nbits,
  output logic ssi_data
);
  int k = 0;
  initial ssi_data = 1'b1;
  // the low half carries no valid bit, so toggling exposes early sampling
  always @(negedge ssi_clk)
    ssi_data <= ~ssi_data;
  always @(posedge ssi_clk)
  begin
    if (rst_b)
    begin
      ssi_data <= frame[int'(nbits) - 1 - k];
      k <= (k + 1 >= int'(nbits)) ? 0 : k + 1;
    end
  end
endmodule // ssi_encoder_model
`default_nettype wire

/* testbench.sv */
// self-checking bench for the serial position decoder
`timescale 1ns/10ps
`default_nettype none
`include "ssi_decoder_defs.vh"
module testbench;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic rep_v = 1'b0;
  logic [5:0] rep_st = 6'h08, rep_mt = 6'h10;
  logic [79:0] frame = 80'h0;
  logic [6:0] nbits = 7'h01;
  wire [31:0] prdata;
  wire [31:0] position;
  wire pready, pslverr, ssi_clk, ssi_data, position_strobe, fa, fb;
  int errors = 0;
  int n_checks = 0;
  int n_pulse = 0;
  int n_strobe = 0;
  int s1 = 0;
  int stw, mtw, lc, tc, motor, seed;
  logic [15:0] lm, tm, rev = 16'h0;
  logic [7:0] lb, tb;
  logic [31:0] exp_pos = 32'h0, est = 32'h0, emt = 32'h0, r, d;
  logic se, sa = 1'b0, sb = 1'b0;
  int seq[4] = '{0, 7, 15, 1};
  ssi_position_decoder #(.CLK_HALF(8), .MONO_CYC(20)) u_dut (
    .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ssi_clk(ssi_clk), .ssi_data(ssi_data), .reported_valid(rep_v),
    .reported_st_bits(rep_st), .reported_mt_bits(rep_mt), .position(position),
    .position_strobe(position_strobe), .extra_bit_fault_a(fa), .extra_bit_fault_b(fb)
  );
  ssi_encoder_model u_enc (.rst_b(rst_b), .ssi_clk(ssi_clk), .frame(frame),
    .nbits(nbits), .ssi_data(ssi_data));
  initial
  begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
    if (position_strobe === 1'b1)
      n_strobe++;
  always @(negedge ssi_clk)
    n_pulse++;
  function automatic logic [31:0] msk(input int w);
    msk = (32'h1 << w) - 32'h1;
  endfunction
  function automatic logic [79:0] cat(input logic [79:0] f, input logic [31:0] v, input int w);
    cat = (f << w) | {48'h0, v & msk(w)};
  endfunction
  function automatic logic flt(input logic [7:0] b, input int c, input logic [15:0] m);
    flt = 1'b0;
    for (int i = 0; i < c; i++)
      if ((m[2*i+:2] == 2'h1 && b[c-1-i])
        || (m[2*i+:2] == 2'h2 && !b[c-1-i]))
        flt = 1'b1;
  endfunction
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    r = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic run(input logic [31:0] mt, input logic [31:0] st);
    int s0;
    int ws;
    int wm;
    logic ea;
    logic eb;
    ws = rep_v ? int'(rep_st) : stw;
    wm = rep_v ? int'(rep_mt) : mtw;
    mt = mt & msk(wm);
    st = st & msk(ws);
    frame = cat(cat(cat(cat(80'h0, lb, lc), mt, wm), st, ws), tb, tc);
    nbits = 7'(lc + wm + ws + tc);
    ea = flt(lb, lc, lm);
    eb = flt(tb, tc, tm);
    s0 = n_strobe;
    n_pulse = 0;
    apb(1'b1, `OFS_CTRL, {30'h0, motor[0], 1'b1});
    repeat (4) @(posedge clk);
    do
      apb(1'b0, `OFS_STATUS, 32'h0);
    while (r[`STAT_BUSY] !== 1'b0);
    repeat (2) @(posedge clk);
    chk("pulses", n_pulse, nbits);
    if (!ea && !eb)
    begin
      if (wm >= 16)
        rev = mt[15:0];
      else if (wm > 0)
      begin
        d = (mt - {16'h0, rev}) & msk(wm);
        rev = rev + d[15:0] - (d >= (32'h1 << (wm - 1)) ? (16'h1 << wm) : 16'h0);
      end
      d = motor ? (ws <= 16 ? st << (16 - ws) : st >> (ws - 16)) : st;
      exp_pos = {rev, d[15:0]};
      est = st;
      emt = mt;
    end
    sa = sa | ea;
    sb = sb | eb;
    chk("position", position, exp_pos);
    chk("strobes", n_strobe - s0, (ea || eb) ? 0 : 1);
    chk("faults", {fa, fb}, {sa, sb});
    apb(1'b0, `OFS_RAW_ST, 32'h0);
    chk("raw st", r, est);
    apb(1'b0, `OFS_RAW_MT, 32'h0);
    chk("raw mt", r, emt);
    if ($urandom % 2)
    begin
      apb(1'b1, `OFS_STATUS, 32'h0000000e);
      sa = 1'b0;
      sb = 1'b0;
    end
  endtask
  task automatic cfg_run(input int s, m, l, input logic [15:0] a, input logic [7:0] b,
      input int t, input logic [15:0] c, input logic [7:0] e, input int o, input logic [31:0] v);
    stw = s;
    mtw = m;
    lc = l;
    lm = a;
    lb = b;
    tc = t;
    tm = c;
    tb = e;
    motor = o;
    apb(1'b1, `OFS_WIDTH, (mtw << 8) | stw);
    apb(1'b1, `OFS_LEAD_MASK, (lc << 16) | lm);
    apb(1'b1, `OFS_TRAIL_MASK, (tc << 16) | tm);
    run(v, $urandom);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    seed = $urandom(60898);
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    apb(1'b0, `OFS_WIDTH, 32'h0);
    chk("width", r, 32'h00000d0d);
    apb(1'b0, `OFS_TRAIL_MASK, 32'h0);
    chk("trail mask", r, 32'h0);
    apb(1'b1, 8'h20, 32'h1);
    chk("slverr", se, 1'b1);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped", r, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 4; i++)
      cfg_run(13, 4, 0, 16'h0, 8'h0, 0, 16'h0, 8'h0, 0, seq[i]);
    $display("test wrap done");
    // continuous reading repeats the last good frame until the mode is switched off
    s1 = n_strobe;
    apb(1'b1, `OFS_CTRL, 32'h00000004);
    repeat (1000) @(posedge clk);
    apb(1'b0, `OFS_CTRL, 32'h0);
    chk("ctrl", r, 32'h00000004);
    apb(1'b1, `OFS_CTRL, 32'h0);
    do
      apb(1'b0, `OFS_STATUS, 32'h0);
    while (r[`STAT_BUSY] !== 1'b0);
    chk("continuous", n_strobe - s1 >= 3, 1'b1);
    chk("position", position, exp_pos);
    $display("test continuous done");
    cfg_run(32, 32, 8, 16'h5555, 8'h01, 8, 16'haaaa, 8'hff, 0, $urandom);
    cfg_run(20, 20, 2, 16'h0001, 8'h01, 3, 16'h0008, 8'h07, 1, $urandom);
    cfg_run(13, 0, 1, 16'h0003, 8'h01, 8, 16'hffff, 8'h5a, 1, $urandom);
    cfg_run(12, 16, 0, 16'h0, 8'h0, 4, 16'h0008, 8'h0b, 0, $urandom);
    $display("test corner done");
    @(posedge clk);
    rep_v <= 1'b1;
    rep_st <= 6'(1 + $urandom % 24);
    rep_mt <= 6'($urandom % 17);
    cfg_run(13, 13, 0, 16'h0, 8'h0, 0, 16'h0, 8'h0, 0, $urandom);
    apb(1'b0, `OFS_WIDTH, 32'h0);
    chk("reported width", r, {18'h0, rep_mt, 2'h0, rep_st});
    @(posedge clk);
    rep_v <= 1'b0;
    $display("test reported done");
    for (int i = 0; i < 14; i++)
      cfg_run(1 + $urandom % 24, 16 + $urandom % 17, $urandom % 9, $urandom, $urandom,
        $urandom % 9, $urandom, $urandom, $urandom % 2, $urandom);
    $display("test random done");
    conclude();
  end
  initial
  begin
    #800000;
    errors++;
    conclude();
  end
endmodule // testbench
bind ssi_position_decoder ssi_decoder_asserts #(.CLK_HALF(CLK_HALF), .MONO_CYC(MONO_CYC)) u_chk (
  .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .ssi_clk(ssi_clk),
  .position(position), .position_strobe(position_strobe),
  .extra_bit_fault_a(extra_bit_fault_a), .extra_bit_fault_b(extra_bit_fault_b)
);
`default_nettype wire
